// File: hdl/cseirq_pkg.sv
// Constants and carrier types for the card event interrupt block
package cseirq_pkg;

    // ****************************************************************
    // Register offsets within the legacy socket register space
    // ****************************************************************
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CONFIG_OFS = 8'h05;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;

    // ****************************************************************
    // Status and configuration bit positions
    // ****************************************************************
    localparam int DETECT_BIT = 3;
    localparam int READY_BIT = 2;
    localparam int BATLOW_BIT = 1;
    localparam int BATFAIL_BIT = 0;
    localparam int ROUTE_LSB = 4;
    localparam logic [3:0] ROUTE_NONE = 4'h0;
    localparam logic [3:0] ROUTE_SMI = 4'h2;

    // Synchroniser depth for card lines
    localparam int SYNC_STAGES = 2;

    // Card lines grouped together as sampled from the socket
    typedef struct packed {
        logic card_detect_a_n;
        logic card_detect_b_n;
        logic ready;
        logic battery_warn_n;
        logic card_status_line_n;
    } cseirq_card_t;

    // Register access request from the host side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cseirq_req_t;

    // Global control bits the block depends on
    typedef struct packed {
        logic ring_function_enable;
        logic card_kind;
        logic event_to_pci_route;
        logic clear_by_write;
        logic diag_event_pci;
    } cseirq_ctl_t;

endpackage : cseirq_pkg

// File: hdl/cseirq_top.sv
// Card status-change detection, flagging and interrupt routing
// Timing, counted in clock edges from a move on a card line:
//   edge 1 loads the first synchroniser stage,
//   edge 2 loads the second stage and exposes the edge,
//   edge 3 sets the sticky flag,
//   edge 4 raises the selected interrupt output.
// A register read strobe is taken on a rising edge and its data
// stands on o_rdata from that same edge until the next read strobe.
// In read-to-clear mode a status read clears every flag on the same
// edge that captures them, so nothing read is lost; a new event on
// that edge still sets its flag, because set beats clear.
// Limitation: a card line pulse shorter than one clock period can
// slip between samples; socket lines move far slower than that.
// After reset the pipeline holds zeros, so idle-high lines show one
// false change; the enables reset to zero, so no flag follows.
module cseirq_top (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire cseirq_pkg::cseirq_card_t i_card,
    input wire cseirq_pkg::cseirq_req_t i_req,
    input wire cseirq_pkg::cseirq_ctl_t i_ctl,
    output logic [7:0] o_rdata,
    output logic [15:0] o_isa_irq,
    output logic o_smi,
    output logic o_pci_irq
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // True when a strobe addresses the given register offset
    function automatic logic hits(
        input logic strobe,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return strobe && (addr == ofs);
    endfunction : hits

    // Next value of one sticky flag: a new event wins over a clear in
    // the same cycle, and a gate that drops forces the flag low at once
    function automatic logic flag_next(
        input logic gate,
        input logic seen,
        input logic now_set,
        input logic clear
    );
        return gate && (seen || (now_set && !clear));
    endfunction : flag_next

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    localparam int NL = $bits(cseirq_pkg::cseirq_card_t);
    logic [NL-1:0] sync1_ff;
    logic [NL-1:0] sync2_ff;
    logic [NL-1:0] prev_ff;
    cseirq_pkg::cseirq_card_t line;
    cseirq_pkg::cseirq_card_t line_prev;

    // Two stages; only the second stage feeds any logic
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync1_ff <= i_card;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // Typed views of the second stage and of the sample before it
    assign line = cseirq_pkg::cseirq_card_t'(sync2_ff);
    assign line_prev = cseirq_pkg::cseirq_card_t'(prev_ff);

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    logic [7:0] config_ff;
    logic [3:0] event_irq_route;
    logic detect_irq_enable;
    logic ready_irq_enable;
    logic battery_low_irq_enable;
    logic battery_fail_irq_enable;
    logic wr_status;
    logic rd_status;

    assign wr_status = hits(i_req.wr, i_req.addr, cseirq_pkg::STATUS_OFS);
    assign rd_status = hits(i_req.rd, i_req.addr, cseirq_pkg::STATUS_OFS);

    // Plain read/write storage, cleared by reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            config_ff <= cseirq_pkg::CONFIG_RST;
        end else if (hits(i_req.wr, i_req.addr, cseirq_pkg::CONFIG_OFS)) begin
            config_ff <= i_req.wdata;
        end
    end

    assign event_irq_route = config_ff[7:cseirq_pkg::ROUTE_LSB];
    assign detect_irq_enable = config_ff[cseirq_pkg::DETECT_BIT];
    assign ready_irq_enable = config_ff[cseirq_pkg::READY_BIT];
    assign battery_low_irq_enable = config_ff[cseirq_pkg::BATLOW_BIT];
    assign battery_fail_irq_enable = config_ff[cseirq_pkg::BATFAIL_BIT];

    // ****************************************************************
    // Event detection
    // ****************************************************************
    logic is_mem;
    logic ev_detect;
    logic ev_ready;
    logic ev_batlow;
    logic ev_fail;
    logic fail_level;

    assign is_mem = !i_ctl.card_kind;
    // Either detect line toggling counts as one change
    assign ev_detect = (line.card_detect_a_n != line_prev.card_detect_a_n)
        || (line.card_detect_b_n != line_prev.card_detect_b_n);
    // Rising ready only means something for memory cards
    assign ev_ready = is_mem && line.ready && !line_prev.ready;
    // Battery warn line is active low; memory cards only
    assign ev_batlow = is_mem && !line.battery_warn_n
        && line_prev.battery_warn_n;
    // Same pin serves as ring when ring mode is on
    assign fail_level = !line.card_status_line_n;
    assign ev_fail = fail_level && line_prev.card_status_line_n;

    // ****************************************************************
    // Sticky status flags
    // ****************************************************************
    logic detect_change_flag_ff;
    logic ready_rise_flag_ff;
    logic battery_low_flag_ff;
    logic battery_fail_flag_ff;
    logic [3:0] clr_mask;

    // Clear mode picks read-to-clear or write-one-to-clear
    // A status write is ignored in read-to-clear mode and a status read
    // leaves the flags alone in write-one mode, so software written for
    // either style cannot wipe events by accident.
    always_comb begin
        clr_mask = 4'h0;
        if (i_ctl.clear_by_write && wr_status) begin
            clr_mask = i_req.wdata[3:0];
        end else if (!i_ctl.clear_by_write && rd_status) begin
            clr_mask = 4'hf;
        end
    end
    // Each flag has its own process so one source can be studied alone;
    // all four share flag_next, so set beats clear everywhere and a
    // disabled source is forced to zero

    // Card detect change on either line
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            detect_change_flag_ff <= 1'b0;
        end else begin
            detect_change_flag_ff <= flag_next(detect_irq_enable,
                ev_detect, detect_change_flag_ff,
                clr_mask[cseirq_pkg::DETECT_BIT]);
        end
    end

    // Ready rise; held at zero while an I/O card sits in the socket
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ready_rise_flag_ff <= 1'b0;
        end else begin
            ready_rise_flag_ff <= flag_next(ready_irq_enable && is_mem,
                ev_ready, ready_rise_flag_ff,
                clr_mask[cseirq_pkg::READY_BIT]);
        end
    end

    // Battery low warning; memory cards only
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            battery_low_flag_ff <= 1'b0;
        end else begin
            battery_low_flag_ff <= flag_next(
                battery_low_irq_enable && is_mem,
                ev_batlow, battery_low_flag_ff,
                clr_mask[cseirq_pkg::BATLOW_BIT]);
        end
    end

    // Battery fail or card status line, any card kind
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            battery_fail_flag_ff <= 1'b0;
        end else begin
            battery_fail_flag_ff <= flag_next(battery_fail_irq_enable,
                ev_fail, battery_fail_flag_ff,
                clr_mask[cseirq_pkg::BATFAIL_BIT]);
        end
    end

    // ****************************************************************
    // Readback
    // ****************************************************************
    logic [7:0] status_view;

    // Upper nibble reserved as zero; enables gate flags again
    assign status_view = {4'h0,
        detect_change_flag_ff && detect_irq_enable,
        ready_rise_flag_ff && ready_irq_enable && is_mem,
        battery_low_flag_ff && battery_low_irq_enable && is_mem,
        battery_fail_flag_ff && battery_fail_irq_enable};

    // Read data is registered, one cycle after the read strobe,
    // and it holds until the next read strobe of any offset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                cseirq_pkg::STATUS_OFS: o_rdata <= status_view;
                cseirq_pkg::CONFIG_OFS: o_rdata <= config_ff;
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Interrupt routing
    // ****************************************************************
    logic pending;
    logic to_pci;

    assign pending = |status_view;
    // Diag bit or route bit selects PCI when code is zero
    assign to_pci = (event_irq_route == cseirq_pkg::ROUTE_NONE)
        ? (i_ctl.diag_event_pci || i_ctl.event_to_pci_route)
        : i_ctl.event_to_pci_route;

    logic route_isa;
    logic [15:0] isa_onehot;

    // Codes other than none and SMI name an ISA line by number
    assign route_isa = (event_irq_route != cseirq_pkg::ROUTE_SMI)
        && (event_irq_route != cseirq_pkg::ROUTE_NONE);
    assign isa_onehot = 16'h0001 << event_irq_route;

    // All three request lines are registered so that a host sees clean
    // levels; the cost is one clock of extra latency after the flag.
    // Only one of them can be high, since PCI routing masks the others.

    // PCI request line
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pci_irq <= 1'b0;
        end else begin
            o_pci_irq <= pending && to_pci;
        end
    end

    // SMI request line
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_smi <= 1'b0;
        end else begin
            o_smi <= pending && !to_pci
                && (event_irq_route == cseirq_pkg::ROUTE_SMI);
        end
    end

    // ISA request lines, one hot or all low
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_isa_irq <= 16'h0000;
        end else if (pending && !to_pci && route_isa) begin
            o_isa_irq <= isa_onehot;
        end else begin
            o_isa_irq <= 16'h0000;
        end
    end

endmodule : cseirq_top

// File: verif/cseirq_bench.sv
// Bench for card event flags and interrupt routing
module cseirq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0;
    logic rst = 1;
    logic c_in = 0, c_rdy = 0, c_low = 0, c_chg = 0, smi, pci, pci_e;
    logic [3:0] code;
    logic [7:0] rdata;
    logic [15:0] isa, isa_e;
    cseirq_pkg::cseirq_card_t card;
    cseirq_pkg::cseirq_req_t req = '0;
    cseirq_pkg::cseirq_ctl_t ctl = '0;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    always #5 clk = ~clk;
    cseirq_card_model cseirq_card_model_i (.i_in(c_in), .i_rdy(c_rdy),
        .i_low(c_low), .i_chg(c_chg), .o_card(card));
    cseirq_top cseirq_top_i (.i_sys_clk(clk), .i_rst(rst), .i_card(card),
        .i_req(req), .i_ctl(ctl), .o_rdata(rdata), .o_isa_irq(isa),
        .o_smi(smi), .o_pci_irq(pci));
    // ****
    // Access and compare tasks
    // ****
    task automatic results;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One-cycle request pulse; read data lands on the edge that samples it
    task automatic acc(input logic r, input logic [7:0] a, logic [7:0] d);
        cyc(1);
        req = '{rd: r, wr: !r, addr: a, wdata: d};
        cyc(1);
        req = '0;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(1, a, 8'h00);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd
    // Hang guard, well beyond the roughly 420 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end
    // Host sequence: find the source, then clear it
    initial begin
        cyc(16);
        rst = 0;
        cyc(4);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00); // Unmapped place reads zero
        {c_in, c_rdy, c_low, c_chg} = 4'hf;
        cyc(6);
        rd(8'h04, 8'h00);
        {c_in, c_rdy, c_low, c_chg} = 4'h0;
        acc(0, 8'h05, 8'h3f);
        rd(8'h05, 8'h3f);
        {c_in, c_rdy, c_low, c_chg} = 4'hf;
        cyc(6);
        chk(isa, 16'h0008);
        rd(8'h04, 8'h0f);
        rd(8'h04, 8'h00);
        cyc(2);
        chk(isa, 16'h0000);
        ctl.clear_by_write = 1;
        c_rdy = 0;
        cyc(3);
        c_rdy = 1;
        cyc(6);
        rd(8'h04, 8'h04);
        acc(0, 8'h04, 8'hfb);
        rd(8'h04, 8'h04);
        acc(0, 8'h04, 8'h04);
        rd(8'h04, 8'h00);
        ctl.card_kind = 1;
        {c_rdy, c_low, c_chg} = 3'h0;
        cyc(3);
        {c_rdy, c_low, c_chg} = 3'h7;
        cyc(6);
        rd(8'h04, 8'h01);
        acc(0, 8'h04, 8'h0f);
        // Every route code, then diag, pci bit and ring cases
        for (int k = 0; k < 19; k++) begin
            code = (k < 16) ? k[3:0] : ((k == 18) ? 4'h5 : 4'h0);
            ctl.diag_event_pci = (k == 16);
            ctl.event_to_pci_route = (k >= 17);
            ctl.ring_function_enable = (k == 18);
            acc(0, 8'h05, {code, 4'h1});
            c_chg = 0;
            cyc(3);
            c_chg = 1;
            cyc(6);
            pci_e = ctl.event_to_pci_route || (code == 0 && ctl.diag_event_pci);
            isa_e = (!pci_e && code != 0 && code != 2) ? 16'h1 << code : 16'h0;
            chk({pci, smi}, {pci_e, !pci_e && code == 4'h2});
            chk(isa, isa_e);
            rd(8'h04, 8'h01);
            acc(0, 8'h04, 8'h01);
            cyc(3);
        end
        results();
    end
endmodule : cseirq_bench

// File: verif/cseirq_card_model.sv
// Socket card model driving the card-side lines
module cseirq_card_model (
    input wire logic i_in,
    input wire logic i_rdy,
    input wire logic i_low,
    input wire logic i_chg,
    output cseirq_pkg::cseirq_card_t o_card
);
    timeunit 1ns;
    timeprecision 1ns;
    // Detect pins pull low when seated; alarm lines are active low
    assign o_card = {~i_in, ~i_in, i_rdy, ~i_low, ~i_chg};
endmodule : cseirq_card_model

// File: verif/cseirq_checker.sv
// Checker for card event flags and interrupt routing
module cseirq_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire cseirq_pkg::cseirq_card_t i_card,
    input wire cseirq_pkg::cseirq_req_t i_req,
    input wire cseirq_pkg::cseirq_ctl_t i_ctl,
    input wire logic [7:0] o_rdata,
    input wire logic [15:0] o_isa_irq,
    input wire logic o_smi,
    input wire logic o_pci_irq
);
    // ****
    // Shadow of the routing and enable register
    // ****
    logic [7:0] cfg_ff;
    logic [3:0] rt;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Follows host writes only, so a stuck design register shows up
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cfg_ff <= 8'h00;
        end else if (i_req.wr && i_req.addr == cseirq_pkg::CONFIG_OFS) begin
            cfg_ff <= i_req.wdata;
        end
    end
    assign rt = cfg_ff[7:4];
    sequence s_st_rd;
        i_req.rd && i_req.addr == cseirq_pkg::STATUS_OFS;
    endsequence
    sequence s_cf_rd;
        i_req.rd && i_req.addr == cseirq_pkg::CONFIG_OFS;
    endsequence
    status_rsvd_a: assert property (s_st_rd |=> o_rdata[7:4] == 4'h0)
        else $error("reserved status bits set");
    reset_quiet_a: assert property ($fell(i_rst) |-> o_rdata == 8'h00
        && o_isa_irq == 16'h0 && !o_smi && !o_pci_irq)
        else $error("outputs not quiet after reset");
    disabled_zero_a: assert property (s_st_rd |=>
        (o_rdata[3:0] & ~$past(cfg_ff[3:0])) == 4'h0)
        else $error("disabled source flag read as set");
    io_bits_a: assert property (s_st_rd ##0 i_ctl.card_kind
        |=> o_rdata[2:1] == 2'h0) else $error("memory bits set for io card");
    cfg_back_a: assert property (s_cf_rd |=> o_rdata == $past(cfg_ff))
        else $error("config readback differs");
    // Request lines are registered: they answer to last cycle's setup
    smi_route_a: assert property (o_smi |-> $past(rt) == 4'h2)
        else $error("smi without its route code");
    isa_route_a: assert property (|o_isa_irq |-> $past(rt) != 4'h0 &&
        $past(rt) != 4'h2 && o_isa_irq == 16'h1 << $past(rt))
        else $error("wrong irq line");
    pci_route_a: assert property (o_pci_irq |->
        $past(i_ctl.event_to_pci_route)
        || ($past(rt) == 4'h0 && $past(i_ctl.diag_event_pci)))
        else $error("pci interrupt without pci routing");
    pci_only_a: assert property ($past(i_ctl.event_to_pci_route) &&
        i_ctl.event_to_pci_route |-> o_isa_irq == 16'h0 && !o_smi)
        else $error("legacy line used while pci routed");
endmodule : cseirq_checker

bind cseirq_top cseirq_checker cseirq_checker_i (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_card(i_card), .i_req(i_req), .i_ctl(i_ctl),
    .o_rdata(o_rdata), .o_isa_irq(o_isa_irq), .o_smi(o_smi),
    .o_pci_irq(o_pci_irq));
